// ==== standby_halt_stop_control.sv ====
// Halt and stop standby controller with APB register access
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module standby_halt_stop_control
  import standby_pkg::*;
#(
  parameter int          N_IRQ         = 8,
  parameter bit          RC_OSC        = 1'b0,
  parameter logic [17:0] WAIT_2P15_CYC = 18'h08000,
  parameter logic [17:0] WAIT_2P17_CYC = 18'h20000
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               halt_exec,
  input  wire logic               stop_exec,
  input  wire logic [N_IRQ-1:0]   irq_request_flag,
  input  wire logic [N_IRQ-1:0]   irq_mask_flag,
  input  wire logic               irq_global_enable,
  input  wire logic               nmi_req,
  input  wire logic               osc_running,
  output logic                    cpu_clk_en,
  output logic                    osc_stop,
  output logic                    osc_out_pullup,
  output logic                    settle_done,
  output logic                    vector_start,
  output logic                    resume_next,
  output logic                    reset_vector_fetch,
  output logic                    port_latch_hold,
  output logic                    timer16_run,
  output logic                    timer8_run,
  output logic                    timer8_ext_only,
  output logic                    wdt_run,
  output logic                    serial_run,
  output logic                    serial_ext_only,
  output logic                    adc_run,
  output logic                    mult_run
);

  // Refuse request widths and wait counts the logic cannot serve
  if (N_IRQ < 1 || N_IRQ > 32 || WAIT_2P15_CYC < 18'h00002
      || WAIT_2P17_CYC < 18'h00002)
  begin : g_bad_param
    $error("standby_halt_stop_control: parameter out of range");
  end

  // -----------------------------------------------------------------------
  // Wait decoding
  // -----------------------------------------------------------------------

  // Stop-release wait for a select code; prohibited codes take the longest
  function automatic logic [17:0] settle_cycles(input logic [2:0] code,
                                                input bit rc);
    logic [17:0] cyc;
    cyc = WAIT_2P17_CYC;
    if (rc)
      cyc = WAIT_2P7_CYC; // RULE4
    else if (code == SEL_2P12)
      cyc = WAIT_2P12_CYC; // RULE2
    else if (code == SEL_2P15)
      cyc = WAIT_2P15_CYC; // RULE2
    else if (code == SEL_2P17)
      cyc = WAIT_2P17_CYC; // RULE2
    return cyc;
  endfunction

  // -----------------------------------------------------------------------
  // Registers and state
  // -----------------------------------------------------------------------
  sb_state_t   state_ff;
  sb_state_t   nxt_state;
  logic [2:0]  settle_sel_ff;
  logic        ack_ff;
  logic        nxt_ack;
  logic [3:0]  rel_cnt_ff;
  logic [3:0]  nxt_rel_cnt;
  logic        vector_ff;
  logic        resume_ff;
  logic        rstvec_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;

  logic        unmasked_req;
  logic        ackable;
  logic        halt_wake;
  logic        cnt_clear;
  logic        cnt_enable;
  logic        cnt_done;
  logic        cnt_busy;
  logic [17:0] cnt_target;
  logic        reset_wait_ff;
  logic        sel_hit;
  logic        sts_hit;
  logic        wr_access;
  logic        setup;
  logic [2:0]  mode_code;

  // -----------------------------------------------------------------------
  // Interrupt qualification
  // -----------------------------------------------------------------------

  // Pending request that a set mask does not block
  assign unmasked_req = |(irq_request_flag & ~irq_mask_flag); // RULE10
  // Acknowledgeable only with request, clear mask and global enable
  assign ackable      = unmasked_req && irq_global_enable; // RULE18
  // Halt ends on an unmasked or non-maskable request
  assign halt_wake    = unmasked_req || nmi_req; // RULE8 RULE11

  // -----------------------------------------------------------------------
  // Stabilization counter
  // -----------------------------------------------------------------------

  // Reset wait is fixed whatever the select register holds
  assign cnt_target = reset_wait_ff
                      ? (RC_OSC ? WAIT_2P7_CYC : WAIT_2P15_CYC) // RULE1 RULE4
                      : settle_cycles(settle_sel_ff, RC_OSC);
  assign cnt_enable = osc_running; // RULE5
  assign cnt_clear  = (state_ff == ST_STOP && nxt_state == ST_SETTLE);

  settle_counter #(
    .W (CNT_W)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (cnt_clear || (reset_wait_ff && !cnt_busy && !cnt_done)),
    .enable  (cnt_enable),
    .target  (cnt_target),
    .done    (cnt_done),
    .busy    (cnt_busy)
  );

  // Marks that the running wait belongs to a reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_wait_ff <= 1'b1; // RULE12 RULE17
    else if (cnt_done)
      reset_wait_ff <= 1'b0;
  end

  // -----------------------------------------------------------------------
  // Standby state machine
  // -----------------------------------------------------------------------

  // Next state, acknowledge decision and release delay
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_ack     = ack_ff;
    nxt_rel_cnt = rel_cnt_ff;
    unique case (state_ff)
      ST_RESET_WAIT:
      begin
        if (cnt_done)
          nxt_state = ST_RUN; // RULE17
      end
      ST_RUN:
      begin
        if (stop_exec)
          nxt_state = ST_STOP; // RULE13
        else if (halt_exec)
          nxt_state = ST_HALT; // RULE6
      end
      ST_HALT:
      begin
        if (halt_wake)
        begin
          nxt_state   = ST_RELEASE; // RULE8
          nxt_ack     = ackable || nmi_req; // RULE10 RULE11
          nxt_rel_cnt = (ackable || nmi_req) ? VEC_DLY_CYC
                                             : RESUME_DLY_CYC; // RULE9
        end
      end
      ST_STOP:
      begin
        if (unmasked_req)
        begin
          nxt_state = ST_SETTLE; // RULE14 RULE16
          nxt_ack   = ackable;
        end
      end
      ST_SETTLE:
      begin
        if (cnt_done)
        begin
          nxt_state   = ST_RELEASE; // RULE16
          nxt_rel_cnt = ack_ff ? VEC_DLY_CYC : RESUME_DLY_CYC;
        end
      end
      ST_RELEASE:
      begin
        if (rel_cnt_ff == 4'h1)
          nxt_state = ST_RUN;
        nxt_rel_cnt = rel_cnt_ff - 4'h1;
      end
      default:
      begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= ST_RESET_WAIT; // RULE12 RULE17
    else
      state_ff <= nxt_state;
  end

  // Acknowledge decision and release countdown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_ff     <= 1'b0;
      rel_cnt_ff <= 4'h0;
    end
    else
    begin
      ack_ff     <= nxt_ack;
      rel_cnt_ff <= nxt_rel_cnt;
    end
  end

  // One-cycle resume, vector and reset-vector strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vector_ff <= 1'b0;
      resume_ff <= 1'b0;
      rstvec_ff <= 1'b0;
    end
    else
    begin
      vector_ff <= state_ff == ST_RELEASE && rel_cnt_ff == 4'h1
                   && ack_ff; // RULE9
      resume_ff <= state_ff == ST_RELEASE && rel_cnt_ff == 4'h1
                   && !ack_ff; // RULE9
      rstvec_ff <= state_ff == ST_RESET_WAIT && cnt_done; // RULE12
    end
  end

  assign vector_start       = vector_ff;
  assign resume_next        = resume_ff;
  assign reset_vector_fetch = rstvec_ff;
  assign settle_done        = cnt_done; // RULE19

  // -----------------------------------------------------------------------
  // Clock and peripheral controls
  // -----------------------------------------------------------------------

  // CPU clock runs only in normal operation
  assign cpu_clk_en = (state_ff == ST_RUN); // RULE6 RULE15
  // Oscillator stopped with its output pin held high
  assign osc_stop       = (state_ff == ST_STOP); // RULE13
  assign osc_out_pullup = (state_ff == ST_STOP); // RULE13
  // Port latches frozen in either standby mode
  assign port_latch_hold = (state_ff == ST_HALT) || (state_ff == ST_STOP)
                           || (state_ff == ST_SETTLE); // RULE7 RULE15
  // Peripherals that keep running through halt; the 8-bit timer and serial run through stop too
  assign timer16_run     = (state_ff != ST_STOP) && (state_ff != ST_SETTLE);
  assign wdt_run         = (state_ff != ST_STOP) && (state_ff != ST_SETTLE);
  assign timer8_run      = 1'b1; // RULE7
  assign serial_run      = 1'b1; // RULE7
  // External count or clock only in stop and through the stabilization wait after it
  assign timer8_ext_only = (state_ff == ST_STOP)
                           || (state_ff == ST_SETTLE); // RULE15
  assign serial_ext_only = (state_ff == ST_STOP)
                           || (state_ff == ST_SETTLE); // RULE15
  // Converter and multiplier stop in any standby mode
  assign adc_run  = (state_ff == ST_RUN) || (state_ff == ST_RELEASE); // RULE7
  assign mult_run = (state_ff == ST_RUN) || (state_ff == ST_RELEASE); // RULE7

  // -----------------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------------
  assign setup     = psel && !penable;
  assign sel_hit   = !RC_OSC && (paddr == SETTLE_SEL_ADDR); // RULE4
  assign sts_hit   = (paddr == STANDBY_STS_ADDR);
  assign wr_access = psel && penable && pwrite;

  // Mode code for status readback
  always_comb
  begin
    mode_code = MODE_RUN;
    unique case (state_ff)
      ST_RESET_WAIT: mode_code = MODE_RESETW;
      ST_RUN:        mode_code = MODE_RUN;
      ST_HALT:       mode_code = MODE_HALT;
      ST_STOP:       mode_code = MODE_STOP;
      ST_SETTLE:     mode_code = MODE_SETTLE;
      ST_RELEASE:    mode_code = MODE_REL;
      default:       mode_code = MODE_RUN;
    endcase
  end

  // Settle-select field, written through the low byte lane only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_sel_ff <= SETTLE_SEL_RST[2:0]; // RULE1
    else if (wr_access && sel_hit && pstrb[0])
      settle_sel_ff <= pwdata[2:0]; // RULE3
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_ff <= !(sel_hit || sts_hit) || (sts_hit && pwrite);
      prdata_ff  <= 32'h0000_0000;
      if (!pwrite && sel_hit)
        prdata_ff <= {24'h000000,
                      SETTLE_SEL_MASK & {5'h00, settle_sel_ff}}; // RULE3
      else if (!pwrite && sts_hit)
      begin
        prdata_ff[STS_MODE_LSB +: 3] <= mode_code;
        prdata_ff[STS_SETTLE_BIT]    <= cnt_busy;
        prdata_ff[STS_ACK_BIT]       <= ack_ff;
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = pslverr_ff & psel & penable;

endmodule

// ==== standby_pkg.sv ====
// Constants and types shared by the standby controller files
// Notes on behaviour
// RULE1: Reset loads select register 04H, yet the post-reset wait is 2^15 cycles.
// RULE2: Select codes 000/010/100 give 2^12/2^15/2^17 cycle stop-release waits.
// RULE3: Select register is 8-bit RW at FFFAH, bits 7..3 zero, field 2..0.
// RULE4: RC build has no select register and a fixed 2^7 cycle wait.
// RULE5: Stabilization wait starts only once the oscillator is running.
// RULE6: Halt gates the CPU clock while the oscillator keeps running.
// RULE7: Halt keeps ports, timers, watchdog, serial, interrupts; converter, multiplier stop.
// RULE8: Any unmasked request ends halt; vector if acknowledgeable, else next instruction.
// RULE9: Halt release takes 9-10 clocks before vectoring, 1-2 before resuming.
// RULE10: Halt: mask 0/IE 0 resumes, mask 0/IE 1 vectors, mask 1 stays halted.
// RULE11: Non-maskable request ends halt and vectors regardless of global enable.
// RULE12: Reset during halt ends it and fetches from the reset vector.
// RULE13: Stop halts the oscillator and pulls its output pin high internally.
// RULE14: Stop enters halt first (here ST_RUN goes straight to ST_STOP); pending unmasked request releases it at once.
// RULE15: Stop halts CPU, 16-bit timer, watchdog, converter, multiplier; ports kept.
// RULE16: Unmasked interrupt ends stop; after the wait, vector or run next instruction.
// RULE17: Reset ends stop, reset proceeds after the wait; masked requests keep stop.
// RULE18: Acknowledgeable means request 1, mask 0 and global enable 1.
// RULE19: Wait is an oscillator cycle counter; completion is a one-cycle pulse.
package standby_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [15:0] SETTLE_SEL_IDX  = 16'hfffa;
  localparam logic [15:0] STANDBY_STS_IDX = 16'hfffb;
  localparam int          PADDR_W         = 18;
  localparam logic [17:0] SETTLE_SEL_ADDR = {SETTLE_SEL_IDX, 2'b00};
  localparam logic [17:0] STANDBY_STS_ADDR = {STANDBY_STS_IDX, 2'b00};
  localparam logic [7:0]  SETTLE_SEL_RST  = 8'h04;
  localparam logic [7:0]  SETTLE_SEL_MASK = 8'h07;

  // Status register field positions
  localparam int STS_MODE_LSB   = 0;
  localparam int STS_SETTLE_BIT = 3;
  localparam int STS_ACK_BIT    = 4;

  // ---------------------------------------------------------------------
  // Settle-select codes and wait counts in oscillator cycles
  // ---------------------------------------------------------------------
  localparam logic [2:0]  SEL_2P12 = 3'h0;
  localparam logic [2:0]  SEL_2P15 = 3'h2;
  localparam logic [2:0]  SEL_2P17 = 3'h4;
  localparam int          CNT_W    = 18;
  localparam logic [17:0] WAIT_2P12_CYC = 18'h01000;
  localparam logic [17:0] WAIT_2P7_CYC  = 18'h00080;

  // Halt release latencies in clocks
  localparam logic [3:0] VEC_DLY_CYC    = 4'h9;
  localparam logic [3:0] RESUME_DLY_CYC = 4'h1;

  // Controller states
  typedef enum logic [2:0] {
    ST_RESET_WAIT,
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_SETTLE,
    ST_RELEASE
  } sb_state_t;

  // Mode code shown in status
  localparam logic [2:0] MODE_RUN    = 3'h0;
  localparam logic [2:0] MODE_HALT   = 3'h1;
  localparam logic [2:0] MODE_STOP   = 3'h2;
  localparam logic [2:0] MODE_SETTLE = 3'h3;
  localparam logic [2:0] MODE_RESETW = 3'h4;
  localparam logic [2:0] MODE_REL    = 3'h5;

endpackage

// ==== settle_counter.sv ====
// Oscillation stabilization wait counter
`timescale 1ns/100ps
module settle_counter
  import standby_pkg::*;
#(
  parameter int W = CNT_W
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clear,
  input  wire logic         enable,
  input  wire logic [W-1:0] target,
  output logic              done,
  output logic              busy
);

  // Refuse a counter too narrow to be useful
  if (W < 8)
  begin : g_bad_width
    $error("settle_counter: width too small");
  end

  logic [W-1:0] cnt_ff;
  logic         done_ff;
  logic         armed_ff;

  // Count oscillator cycles only while oscillation runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= '0;
    else if (clear || done_ff)
      cnt_ff <= '0;
    else if (enable && armed_ff)
      cnt_ff <= cnt_ff + 1'b1; // RULE5 RULE19
  end

  // Armed from clear until the completion pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_ff <= 1'b0;
    else if (clear)
      armed_ff <= 1'b1;
    else if (done_ff)
      armed_ff <= 1'b0;
  end

  // One-cycle completion pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_ff <= 1'b0;
    else
      done_ff <= !clear && !done_ff && armed_ff && enable
                 && (cnt_ff == target - 1'b1); // RULE19
  end

  assign done = done_ff;
  assign busy = armed_ff;

endmodule

// ==== standby_halt_stop_control_props.sv ====
// Port-level assertion checker for the standby controller
`timescale 1ns/100ps
module standby_halt_stop_control_chk
  import standby_pkg::*;
#(
  parameter int N_IRQ = 8
)
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               halt_exec,
  input wire logic               stop_exec,
  input wire logic [N_IRQ-1:0]   irq_request_flag,
  input wire logic [N_IRQ-1:0]   irq_mask_flag,
  input wire logic               nmi_req,
  input wire logic               cpu_clk_en,
  input wire logic               osc_stop,
  input wire logic               osc_out_pullup,
  input wire logic               settle_done,
  input wire logic               vector_start,
  input wire logic               resume_next,
  input wire logic               reset_vector_fetch,
  input wire logic               port_latch_hold,
  input wire logic               timer16_run,
  input wire logic               timer8_ext_only,
  input wire logic               wdt_run,
  input wire logic               serial_ext_only,
  input wire logic               adc_run,
  input wire logic               mult_run
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] rel_cnt_ff;
  logic       unmasked;
  logic       halted;
  // Halt is the only state holding ports with the 16-bit timer running
  assign unmasked = |(irq_request_flag & ~irq_mask_flag);
  assign halted   = port_latch_hold & timer16_run & ~adc_run;
  // Length of the release phase, cleared outside it
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rel_cnt_ff <= 4'h0;
    else if (adc_run && !cpu_clk_en && rel_cnt_ff != 4'hf)
      rel_cnt_ff <= rel_cnt_ff + 4'h1;
    else if (cpu_clk_en)
      rel_cnt_ff <= 4'h0;
  // -------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------
  property p_halt_in;
    halt_exec && cpu_clk_en && !stop_exec |=> halted && !cpu_clk_en
      && !osc_stop && !adc_run && !mult_run && wdt_run;
  endproperty
  a_halt_in: assert property (p_halt_in)
    else $error("halt entry levels wrong");
  property p_stop_in;
    stop_exec && cpu_clk_en |=> osc_stop && osc_out_pullup && !cpu_clk_en;
  endproperty
  a_stop_in: assert property (p_stop_in)
    else $error("stop entry levels wrong");
  property p_stop_lvl;
    osc_stop |-> port_latch_hold && !timer16_run && !wdt_run && !adc_run
      && !mult_run && timer8_ext_only && serial_ext_only;
  endproperty
  a_stop_lvl: assert property (p_stop_lvl)
    else $error("stop peripheral levels wrong");
  property p_halt_wake;
    halted && (unmasked || nmi_req) |=> adc_run && !cpu_clk_en;
  endproperty
  a_halt_wake: assert property (p_halt_wake)
    else $error("halt not released");
  property p_halt_keep;
    halted && !unmasked && !nmi_req |=> halted;
  endproperty
  a_halt_keep: assert property (p_halt_keep)
    else $error("halt left without cause");
  property p_stop_wake;
    osc_stop && unmasked |=> !osc_stop && !timer16_run && !cpu_clk_en;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("stop not released");
  property p_stop_keep;
    osc_stop && !unmasked |=> osc_stop;
  endproperty
  a_stop_keep: assert property (p_stop_keep)
    else $error("stop left without cause");
  property p_vec_dly;
    vector_start |-> cpu_clk_en && rel_cnt_ff == 4'h9;
  endproperty
  a_vec_dly: assert property (p_vec_dly)
    else $error("vector delay wrong");
  property p_res_dly;
    resume_next |-> cpu_clk_en && rel_cnt_ff == 4'h1;
  endproperty
  a_res_dly: assert property (p_res_dly)
    else $error("resume delay wrong");
  property p_pulse;
    settle_done |=> !settle_done;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("settle pulse too long");
  property p_rst_fetch;
    reset_vector_fetch |-> $past(settle_done) && cpu_clk_en;
  endproperty
  a_rst_fetch: assert property (p_rst_fetch)
    else $error("reset fetch before wait end");
  property p_rd_sel;
    psel && penable && !pwrite && paddr == SETTLE_SEL_ADDR |->
      pready && prdata[31:3] == 29'h0;
  endproperty
  a_rd_sel: assert property (p_rd_sel)
    else $error("select read upper bits set");
  c_vec: cover property (vector_start);
  c_res: cover property (resume_next);
  c_rst: cover property (reset_vector_fetch);
  c_stop: cover property (osc_stop && unmasked);
endmodule

bind standby_halt_stop_control standby_halt_stop_control_chk
  #(.N_IRQ(N_IRQ)) u_chk (.*);

// ==== osc_model.sv ====
// Oscillator model: stops on request, restarts after a start-up delay
`timescale 1ns/100ps
module osc_model
#(
  parameter int START_DLY = 6
)
(
  input  wire logic pclk,
  input  wire logic osc_stop,
  output logic      osc_running
);
  int start_cnt_ff = 0;
  initial osc_running = 1'b1;
  // Start-up gap lies before counting may begin
  always @(posedge pclk)
    if (osc_stop)
    begin
      start_cnt_ff <= 0;
      osc_running  <= 1'b0;
    end
    else if (!osc_running)
    begin
      start_cnt_ff <= start_cnt_ff + 1;
      osc_running  <= (start_cnt_ff + 1 >= START_DLY);
    end
endmodule

// ==== standby_halt_stop_control_test.sv ====
// Self-checking bench for the standby controller
`timescale 1ns/100ps
module standby_halt_stop_control_test
  import standby_pkg::*;
;
  localparam logic [17:0] W15 = 18'h00014;
  localparam logic [17:0] W17 = 18'h00028;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, ev;
  logic        halt_exec, stop_exec, irq_global_enable, nmi_req, err;
  logic [7:0]  irq_request_flag, irq_mask_flag;
  logic        osc_running, cpu_clk_en, osc_stop, osc_out_pullup;
  logic        settle_done, vector_start, resume_next, reset_vector_fetch;
  logic        port_latch_hold, timer16_run, timer8_run, timer8_ext_only;
  logic        wdt_run, serial_run, serial_ext_only, adc_run, mult_run;
  int          n_mismatch, checks_done, cycles, n;
  logic [2:0]  codes[4] = '{3'h0, 3'h2, 3'h4, 3'h7};
  logic [17:0] tgts[4] = '{WAIT_2P12_CYC, W15, W17, W17};
  assign ev = {reset_vector_fetch, settle_done, resume_next, vector_start};
  standby_halt_stop_control #(.WAIT_2P15_CYC(W15), .WAIT_2P17_CYC(W17))
    dut (.*);
  osc_model u_osc (.pclk(pclk), .osc_stop(osc_stop), .osc_running(osc_running));
  // -------------------------------------------------------------------
  // Clock, timeout and tasks
  // -------------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Cuts a hung run short
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_ev(input int k, input int lim);
    n = 0;
    while (ev[k] !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk("event seen", 1, ev[k]);
  endtask
  // Waits counted from oscillator start, not from release
  task automatic settle_meas(input logic [17:0] t);
    n = 0;
    while (osc_running !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    wait_ev(2, 5000);
    chk("settle cycles", 1, n >= t && n <= t + 3);
  endtask
  task automatic rst_release();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("clock gated in reset", 0, cpu_clk_en);
    presetn <= 1'b1;
    settle_meas(W15);
    wait_ev(3, 5);
  endtask
  task automatic halt_case(input logic [7:0] msk, input logic ie,
                           input logic nm, input int k, input int lo);
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec         <= 1'b0;
    irq_mask_flag     <= msk;
    irq_global_enable <= ie;
    @(posedge pclk);
    chk("halt gates clock", 0, cpu_clk_en);
    irq_request_flag <= 8'h01;
    nmi_req          <= nm;
    if (msk[0] && !nm)
    begin
      repeat (10) @(posedge pclk);
      chk("masked keeps halt", 0, cpu_clk_en);
      irq_mask_flag <= 8'h00;
    end
    wait_ev(k, 40);
    chk("halt release delay", 1, n >= lo && n <= lo + 2);
    irq_request_flag <= 8'h00;
    nmi_req          <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stop_case(input logic [2:0] c, input logic [17:0] t);
    apb(1'b1, SETTLE_SEL_ADDR, {29'h0, c}, 4'h1);
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec         <= 1'b0;
    irq_request_flag  <= 8'h01;
    irq_mask_flag     <= 8'h01;
    irq_global_enable <= 1'b1;
    nmi_req           <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("stop held", 1, osc_stop & osc_out_pullup & ~timer16_run);
    chk("external-clock units kept", 1, timer8_run & serial_run);
    apb(1'b0, STANDBY_STS_ADDR, 32'h0, 4'h1);
    chk("status mode", {29'h0, MODE_STOP}, rd & 32'h7);
    irq_mask_flag <= 8'h00;
    settle_meas(t);
    wait_ev(0, 30);
    irq_request_flag <= 8'h00;
    nmi_req          <= 1'b0;
    @(posedge pclk);
  endtask
  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, halt_exec, stop_exec} = 6'h00;
    {irq_global_enable, nmi_req, paddr, pwdata, pstrb} = 56'h0;
    {irq_request_flag, irq_mask_flag} = 16'h0000;
    {n_mismatch, checks_done, cycles} = 96'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle_meas(W15);
    wait_ev(3, 5);
    apb(1'b0, SETTLE_SEL_ADDR, 32'h0, 4'h1);
    chk("select reset value", 32'h00000004, rd);
    apb(1'b1, SETTLE_SEL_ADDR, 32'hffffffff, 4'h1);
    apb(1'b0, SETTLE_SEL_ADDR, 32'h0, 4'h1);
    chk("select upper zero", 32'h00000007, rd);
    apb(1'b1, SETTLE_SEL_ADDR, 32'h0, 4'h0);
    apb(1'b0, SETTLE_SEL_ADDR, 32'h0, 4'h1);
    chk("laneless write", 32'h00000007, rd);
    apb(1'b0, 18'h00100, 32'h0, 4'h1);
    chk("unmapped error", 1, err);
    apb(1'b1, STANDBY_STS_ADDR, 32'h0, 4'h1);
    chk("status write error", 1, err);
    $display("test registers done");
    halt_case(8'h00, 1'b0, 1'b0, 1, 2);
    halt_case(8'h00, 1'b1, 1'b0, 0, 10);
    halt_case(8'h01, 1'b0, 1'b1, 0, 10);
    halt_case(8'h01, 1'b0, 1'b0, 1, 2);
    $display("test halt done");
    for (int i = 0; i < 4; i++)
      stop_case(codes[i], tgts[i]);
    irq_request_flag <= 8'h01;
    stop_exec        <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
    repeat (2) @(posedge pclk);
    settle_meas(W17);
    wait_ev(0, 30);
    irq_request_flag <= 8'h00;
    @(posedge pclk);
    $display("test stop done");
    halt_exec <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    @(posedge pclk);
    rst_release();
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
    repeat (3) @(posedge pclk);
    rst_release();
    $display("test reset done");
    wrap_up();
  end
endmodule
